// File: cbs_consts.svh
// register offsets, reset values and limits of the channel select block
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

`define CBS_OFF_CTRL      8'h00
`define CBS_OFF_MASK      8'h04
`define CBS_OFF_LEN       8'h08
`define CBS_OFF_CAP       8'h0C
`define CBS_OFF_STAT      8'h10
`define CBS_OFF_SWEEPS    8'h14
`define CBS_OFF_POINTS    8'h18
`define CBS_OFF_CMD       8'h1C
`define CBS_OFF_RDSEL     8'h20

`define CBS_CTRL_MODE_BIT 0
`define CBS_CTRL_DUAL_BIT 1
`define CBS_CTRL_CURRENT_INPUT_MODE_LO 2
`define CBS_CMD_REINIT    0
`define CBS_ST_PERR       0
`define CBS_ST_MREJ       1
`define CBS_ST_RDOK       2

`define CBS_STORE_POINTS  17'd100000
`define CBS_FAST_MAX_LEN  17'd100000
`define CBS_MASK_RESET    22'h00_0001
`define CBS_LEN_RESET     17'd100000
`define CBS_SINGLE_BITS   17
`define CBS_DUAL_BITS     22
`define CBS_FREQ_LO_CH    15
`define CBS_FREQ_HI_CH    16
`define CBS_FS_SIGNED     16'sd10000
`define CBS_FS_PHASE      16'sd18000
`define CBS_LOG_MIN       16'sd3000
`define CBS_LOG_MAX       16'sd2000
`define CBS_EVENT_MAX     16'h7FFF
`define CBS_GAIN_MAX      5'd27

`endif

// File: cbs_pkg.sv
// types shared by the channel select block
package cbs_pkg;
    typedef enum logic {CBS_STANDARD, CBS_FAST} cbs_mode_t;
    typedef enum logic [2:0] {
        CBS_FMT_SIGNED, CBS_FMT_UNSIGNED, CBS_FMT_PHASE, CBS_FMT_SENS,
        CBS_FMT_LOG, CBS_FMT_EVENT, CBS_FMT_FREQ_LO, CBS_FMT_FREQ_HI
    } cbs_fmt_t;
endpackage : cbs_pkg

// File: cbs_sample_encode.sv
// combinational encoder from raw channel value to stored 16-bit integer
`timescale 1ns/1ns
`include "cbs_consts.svh"
module cbs_sample_encode (
    // selected channel
    input  wire logic [4:0]         chan,
    // raw values
    input  wire logic signed [31:0] raw,
    input  wire logic [31:0]        freq_mhz,
    input  wire logic [4:0]         gain_idx,
    input  wire logic [1:0]         current_input_mode,
    input  wire logic [14:0]        event_val,
    // encoded word
    output logic [15:0]             word
);
    // ==========================================================
    // helpers
    function automatic logic [15:0] clamp(input logic signed [31:0] v,
                                          input logic signed [31:0] lo,
                                          input logic signed [31:0] hi);
        if (v < lo) clamp = lo[15:0];
        else if (v > hi) clamp = hi[15:0];
        else clamp = v[15:0];
    endfunction : clamp

    function automatic cbs_pkg::cbs_fmt_t fmt_of(input logic [4:0] c);
        case (c)
            5'd2, 5'd5, 5'd19: fmt_of = cbs_pkg::CBS_FMT_UNSIGNED;
            5'd3, 5'd20:       fmt_of = cbs_pkg::CBS_FMT_PHASE;
            5'd4, 5'd21:       fmt_of = cbs_pkg::CBS_FMT_SENS;
            5'd7:              fmt_of = cbs_pkg::CBS_FMT_LOG;
            5'd14:             fmt_of = cbs_pkg::CBS_FMT_EVENT;
            5'd15:             fmt_of = cbs_pkg::CBS_FMT_FREQ_LO;
            5'd16:             fmt_of = cbs_pkg::CBS_FMT_FREQ_HI;
            default:           fmt_of = cbs_pkg::CBS_FMT_SIGNED;
        endcase
    endfunction : fmt_of

    // ==========================================================
    // encoding
    logic [7:0] current_input_mode_off;
    logic [4:0] gain_c;

    always_comb begin
        case (current_input_mode)
            2'd1:    current_input_mode_off = 8'd32;
            2'd2:    current_input_mode_off = 8'd64;
            2'd3:    current_input_mode_off = 8'd128;
            default: current_input_mode_off = 8'd0;
        endcase
        // gain index kept inside 1..27 so the offset field stays clean
        if (gain_idx == 5'd0) gain_c = 5'd1;
        else if (gain_idx > `CBS_GAIN_MAX) gain_c = `CBS_GAIN_MAX;
        else gain_c = gain_idx;
        case (fmt_of(chan))
            cbs_pkg::CBS_FMT_UNSIGNED: word = clamp(raw, 0, `CBS_FS_SIGNED);      // R10
            cbs_pkg::CBS_FMT_PHASE:    word = clamp(raw, -`CBS_FS_PHASE,
                                                    `CBS_FS_PHASE);               // R11
            cbs_pkg::CBS_FMT_SENS:     word = {8'h00, current_input_mode_off} + {11'd0, gain_c}; // R12
            cbs_pkg::CBS_FMT_LOG:      word = clamp(raw, -`CBS_LOG_MIN,
                                                    `CBS_LOG_MAX);                // R13
            cbs_pkg::CBS_FMT_EVENT:    word = {1'b0, event_val};                  // R14
            cbs_pkg::CBS_FMT_FREQ_LO:  word = freq_mhz[15:0];                     // R15
            cbs_pkg::CBS_FMT_FREQ_HI:  word = freq_mhz[31:16];                    // R15
            default:                   word = clamp(raw, -`CBS_FS_SIGNED,
                                                    `CBS_FS_SIGNED);              // R10
        endcase
    end
endmodule : cbs_sample_encode

// File: cbs_curve_buffer_select.sv
// channel selection and store sharing for the capture buffer, apb slave
//
// Overview of operation
// R1: mode 0 standard, mode 1 fast
// R2: single reference mask 17 bits, 1..131071
// R3: dual modes widen mask to 22 bits
// R4: set mask bit stores channel, clear excludes
// R5: standard store shared evenly among slots
// R6: reference frequency takes two slots
// R7: bits 15 and 16 always set together
// R8: length clamped to store over slot count
// R9: host includes one of bits 17..20
// R10: xy ratio signed, magnitude noise unsigned
// R11: phase signed, 18000 means 180 degrees
// R12: sensitivity is gain plus input mode offset
// R13: log ratio held within -3000..+2000
// R14: event marker stored as 0..32767
// R15: frequency millihertz, low then high half
// R16: dual bits 17..21 select second demodulator
// R17: host should store sensitivity channels
// R18: readout index limited to selected channels
// R19: oversize length flags parameter error
// R20: counters clear on bare read or reinit
// R21: no dual mode: high mask bits rejected
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "cbs_consts.svh"
module cbs_curve_buffer_select #(
    parameter int MASK_W = `CBS_DUAL_BITS,
    parameter int LEN_W  = 17,
    parameter int CNT_W  = 32
) (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // acquisition events from the capture engine
    input  wire logic                point_done,
    input  wire logic                sweep_done,
    // raw sample stream
    input  wire logic                sample_valid,
    input  wire logic [4:0]          sample_chan,
    input  wire logic signed [31:0]  sample_raw,
    input  wire logic [31:0]         freq_mhz,
    input  wire logic [4:0]          gain_idx,
    input  wire logic [4:0]          gain_idx2,
    input  wire logic [14:0]         event_val,
    // encoded store stream
    output logic                     store_en,
    output logic [4:0]               store_chan,
    output logic [15:0]              store_word,
    // configuration seen by the capture engine
    output logic                     fast_mode,
    output logic [MASK_W-1:0]        sel_mask,
    output logic [LEN_W-1:0]         curve_len
);
    // ==========================================================
    // helpers
    function automatic logic [4:0] slot_count(input logic [MASK_W-1:0] m);
        logic [4:0] n;
        n = 5'd0;
        for (int i = 0; i < MASK_W; i++) begin
            n = n + {4'd0, m[i]};
        end
        slot_count = n;
    endfunction : slot_count

    function automatic logic [LEN_W-1:0] cap_of(input logic [4:0] slots);
        if (slots == 5'd0) cap_of = `CBS_STORE_POINTS;
        else cap_of = LEN_W'(`CBS_STORE_POINTS / {12'd0, slots});
    endfunction : cap_of

    function automatic logic [MASK_W-1:0] pair_freq(input logic [MASK_W-1:0] m);
        logic [MASK_W-1:0] r;
        r = m;
        if (m[`CBS_FREQ_LO_CH] | m[`CBS_FREQ_HI_CH]) begin
            r[`CBS_FREQ_LO_CH] = 1'b1;
            r[`CBS_FREQ_HI_CH] = 1'b1;
        end
        pair_freq = r;
    endfunction : pair_freq

    // ==========================================================
    // apb handshake: one wait state, answer in second access cycle
    logic       pready_r;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       mapped;

    assign acc = psel & penable & pready_r;
    assign wr  = acc & pwrite;
    assign rd  = acc & ~pwrite;

    always_comb begin
        case (paddr)
            `CBS_OFF_CTRL, `CBS_OFF_MASK, `CBS_OFF_LEN, `CBS_OFF_CAP,
            `CBS_OFF_STAT, `CBS_OFF_SWEEPS, `CBS_OFF_POINTS,
            `CBS_OFF_CMD, `CBS_OFF_RDSEL: mapped = 1'b1;
            default:                      mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pready_r <= 1'b0;
        else pready_r <= psel & penable & ~pready_r;
    end

    // ==========================================================
    // control register
    cbs_pkg::cbs_mode_t mode_r;
    logic               dual_r;
    logic [1:0]         current_input_mode_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r  <= cbs_pkg::CBS_STANDARD;
            dual_r  <= 1'b0;
            current_input_mode_r <= 2'd0;
        end else if (wr && paddr == `CBS_OFF_CTRL) begin
            mode_r  <= pwdata[`CBS_CTRL_MODE_BIT] ? cbs_pkg::CBS_FAST
                                                  : cbs_pkg::CBS_STANDARD; // R1
            dual_r  <= pwdata[`CBS_CTRL_DUAL_BIT];
            current_input_mode_r <= pwdata[`CBS_CTRL_CURRENT_INPUT_MODE_LO +: 2];
        end
    end

    // ==========================================================
    // selection mask and curve length
    logic [MASK_W-1:0] mask_r;
    logic [MASK_W-1:0] mask_nxt;
    logic [LEN_W-1:0]  len_r;
    logic [LEN_W-1:0]  cap;
    logic              mask_ok;
    logic              len_ok;
    logic              mask_wr;
    logic              len_wr;

    assign mask_nxt = pair_freq(pwdata[MASK_W-1:0]);                              // R7
    assign cap      = cap_of(slot_count(mask_r));                                 // R5 R6
    // zero, or any bit past the width of the active mode, is refused
    assign mask_ok  = (pwdata[MASK_W-1:0] != '0) && (pwdata[31:MASK_W] == '0) &&
                      (dual_r || pwdata[MASK_W-1:`CBS_SINGLE_BITS] == '0);       // R2 R3 R21
    assign mask_wr  = wr && paddr == `CBS_OFF_MASK;
    assign len_wr   = wr && paddr == `CBS_OFF_LEN;
    assign len_ok   = (pwdata[31:LEN_W] == '0) && (pwdata[LEN_W-1:0] != '0) &&
                      (mode_r == cbs_pkg::CBS_FAST ?
                       pwdata[LEN_W-1:0] <= `CBS_FAST_MAX_LEN :
                       pwdata[LEN_W-1:0] <= cap);                                 // R19

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mask_r <= `CBS_MASK_RESET;
        else if (mask_wr && mask_ok) mask_r <= mask_nxt;                          // R4 R16
    end

    // in standard mode length is cut down to the slot cap one cycle after the mask moves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) len_r <= `CBS_LEN_RESET;
        else if (len_wr && len_ok) len_r <= pwdata[LEN_W-1:0];
        else if (mode_r == cbs_pkg::CBS_STANDARD && len_r > cap) len_r <= cap;    // R8
    end

    // ==========================================================
    // status flags, write one to clear, a new error wins over the clear
    logic perr_r;
    logic mrej_r;
    logic st_clr;

    assign st_clr = wr && paddr == `CBS_OFF_STAT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            perr_r <= 1'b0;
            mrej_r <= 1'b0;
        end else begin
            if (len_wr && !len_ok) perr_r <= 1'b1;                                // R19
            else if (st_clr && pwdata[`CBS_ST_PERR]) perr_r <= 1'b0;
            if (mask_wr && !mask_ok) mrej_r <= 1'b1;                              // R21
            else if (st_clr && pwdata[`CBS_ST_MREJ]) mrej_r <= 1'b0;
        end
    end

    // ==========================================================
    // readout channel check
    logic [4:0] rdsel_r;
    logic       rdok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rdsel_r <= 5'd0;
        else if (wr && paddr == `CBS_OFF_RDSEL) rdsel_r <= pwdata[4:0];
    end

    assign rdok = ({27'd0, rdsel_r} < MASK_W) && mask_r[rdsel_r];                 // R18

    // ==========================================================
    // sweep and point counters
    logic [CNT_W-1:0] sweeps_r;
    logic [CNT_W-1:0] points_r;
    logic             cnt_clr;

    // a bare read of mask or length zeroes both, as does reinit
    assign cnt_clr = (rd && (paddr == `CBS_OFF_MASK || paddr == `CBS_OFF_LEN)) ||
                     (wr && paddr == `CBS_OFF_CMD && pwdata[`CBS_CMD_REINIT]);    // R20

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sweeps_r <= '0;
            points_r <= '0;
        end else if (cnt_clr) begin
            sweeps_r <= '0;                                                       // R20
            points_r <= '0;
        end else begin
            if (sweep_done) sweeps_r <= sweeps_r + 1'b1;
            if (point_done) points_r <= points_r + 1'b1;
        end
    end

    // ==========================================================
    // read data and error answer
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr)
            `CBS_OFF_CTRL:   rdata = {28'd0, current_input_mode_r, dual_r, mode_r == cbs_pkg::CBS_FAST};
            `CBS_OFF_MASK:   rdata = 32'(mask_r);
            `CBS_OFF_LEN:    rdata = 32'(len_r);
            `CBS_OFF_CAP:    rdata = 32'(cap);
            `CBS_OFF_STAT:   rdata = {29'd0, rdok, mrej_r, perr_r};
            `CBS_OFF_SWEEPS: rdata = 32'(sweeps_r);
            `CBS_OFF_POINTS: rdata = 32'(points_r);
            `CBS_OFF_RDSEL:  rdata = {27'd0, rdsel_r};
            default:         rdata = 32'h0000_0000;
        endcase
    end

    logic [31:0] prdata_r;
    logic        pslverr_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= (psel & penable & ~pready_r & ~pwrite) ? rdata : 32'h0000_0000;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
        end
    end

    assign pready  = pready_r;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // ==========================================================
    // sample encoding and store gating
    logic [15:0] enc_word;
    logic [4:0]  gain_sel;
    logic        store_en_r;
    logic [4:0]  store_chan_r;
    logic [15:0] store_word_r;

    // second sensitivity channel reports the second gain
    assign gain_sel = (sample_chan == 5'd21) ? gain_idx2 : gain_idx;

    cbs_sample_encode i_cbs_sample_encode (
        .chan      (sample_chan),
        .raw       (sample_raw),
        .freq_mhz  (freq_mhz),
        .gain_idx  (gain_sel),
        .current_input_mode     (current_input_mode_r),
        .event_val (event_val),
        .word      (enc_word)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_en_r   <= 1'b0;
            store_chan_r <= 5'd0;
            store_word_r <= 16'h0000;
        end else begin
            store_en_r   <= sample_valid && ({27'd0, sample_chan} < MASK_W) &&
                            mask_r[sample_chan];                                  // R4
            store_chan_r <= sample_chan;
            store_word_r <= enc_word;                                             // R10
        end
    end

    assign store_en   = store_en_r;
    assign store_chan = store_chan_r;
    assign store_word = store_word_r;
    assign fast_mode  = (mode_r == cbs_pkg::CBS_FAST);                            // R1
    assign sel_mask   = mask_r;
    assign curve_len  = len_r;

    // ==========================================================
    // assertions
    property p_mode_follows;                                                      // R1
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `CBS_OFF_CTRL) |=> (fast_mode == $past(pwdata[0]));
    endproperty
    a_mode_follows: assert property (p_mode_follows) else $error("mode not taken");

    property p_single_width;                                                      // R2
        @(posedge pclk) disable iff (!presetn)
        (mask_wr && !dual_r && pwdata[21:17] != 5'd0) |=> $stable(mask_r) && mrej_r;
    endproperty
    a_single_width: assert property (p_single_width) else $error("wide mask taken");

    property p_mask_nonzero;                                                      // R2
        @(posedge pclk) disable iff (!presetn)
        mask_r != '0;
    endproperty
    a_mask_nonzero: assert property (p_mask_nonzero) else $error("empty mask");

    property p_freq_pair;                                                         // R7
        @(posedge pclk) disable iff (!presetn)
        mask_r[15] == mask_r[16];
    endproperty
    a_freq_pair: assert property (p_freq_pair) else $error("frequency halves split");

    property p_len_clamp;                                                         // R8
        @(posedge pclk) disable iff (!presetn)
        (mask_wr && mask_ok && mode_r == cbs_pkg::CBS_STANDARD) |-> ##[1:2] len_r <= cap;
    endproperty
    a_len_clamp: assert property (p_len_clamp) else $error("length not reduced");

    property p_store_gate;                                                        // R4
        @(posedge pclk) disable iff (!presetn)
        (sample_valid && sample_chan < 5'd22 && !mask_r[sample_chan]) |=> !store_en;
    endproperty
    a_store_gate: assert property (p_store_gate) else $error("unselected stored");

    property p_len_err;                                                           // R19
        @(posedge pclk) disable iff (!presetn)
        (len_wr && mode_r == cbs_pkg::CBS_STANDARD && pwdata[16:0] > cap &&
         pwdata[31:17] == 15'd0) |=> perr_r && len_r <= $past(len_r);
    endproperty
    a_len_err: assert property (p_len_err) else $error("oversize length taken");

    property p_cnt_clear;                                                         // R20
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == `CBS_OFF_MASK) |=> (points_r == '0 && sweeps_r == '0);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counters not cleared");

    property p_readout;                                                           // R18
        @(posedge pclk) disable iff (!presetn)
        (rdsel_r < 5'd22 && !mask_r[rdsel_r]) |-> !rdok;
    endproperty
    a_readout: assert property (p_readout) else $error("unselected readout allowed");

    property p_phase_range;                                                       // R11
        @(posedge pclk) disable iff (!presetn)
        (store_en && store_chan == 5'd3) |->
            ($signed(store_word) <= 16'sd18000 && $signed(store_word) >= -16'sd18000);
    endproperty
    a_phase_range: assert property (p_phase_range) else $error("phase out of range");
endmodule : cbs_curve_buffer_select

// File: cbs_host_model.sv
// apb master standing in for the host that sends configuration
`timescale 1ns/1ns
module cbs_host_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // request from the bench
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic [31:0]      rd_data,
    output logic             err,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {psel, penable, pwrite, done, err} <= 5'h0;
            paddr <= 8'h00;
            pwdata <= 32'h0000_0000;
            rd_data <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            if (psel && penable && pready) begin
                rd_data <= prdata;
                err <= pslverr;
                done <= 1'b1;
                psel <= 1'b0;
                penable <= 1'b0;
                // released lines must not keep looking valid
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (start) begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= wdata;
            end
        end
    end
endmodule : cbs_host_model

// File: curve_buffer_channel_select_bench.sv
// self-checking bench for the channel select block
`timescale 1ns/1ns
`include "cbs_consts.svh"
module curve_buffer_channel_select_bench;
    logic pclk = 0, presetn = 0, start = 0, wr = 0, done, err;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] addr = 0, paddr;
    logic [31:0] wdata = 0, rd_data, pwdata, prdata;
    logic point_done = 0, sweep_done = 0, sample_valid = 0, store_en, fast_mode;
    logic [4:0] sample_chan = 0, gain_idx = 5'd30, gain_idx2 = 5'd3, store_chan;
    logic signed [31:0] sample_raw = 0;
    logic [31:0] freq_mhz = 32'h1234_5678;
    logic [14:0] event_val = 15'h7FFF;
    logic [15:0] store_word;
    logic [21:0] sel_mask;
    logic [16:0] curve_len;
    int n_errors = 0, total_checks = 0, cyc = 0;
    cbs_curve_buffer_select i_cbs_curve_buffer_select (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .point_done, .sweep_done,
        .sample_valid, .sample_chan, .sample_raw, .freq_mhz, .gain_idx, .gain_idx2,
        .event_val, .store_en, .store_chan, .store_word, .fast_mode, .sel_mask, .curve_len);
    cbs_host_model i_cbs_host_model (.pclk, .presetn, .start, .wr, .addr, .wdata, .done,
        .rd_data, .err, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
    // ==========================================
    // helpers
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        start <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge pclk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        if (n >= 20) chk("apb done", 1, 0);
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                         input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd_data & m);
    endtask : rdchk
    task automatic send(input logic [4:0] c, input logic signed [31:0] r);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_chan <= c;
        sample_raw <= r;
        @(posedge pclk);
        sample_valid <= 1'b0;
        #1;
    endtask : send
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // ==========================================
    // scenarios
    task automatic t_pair();
        rdchk(`CBS_OFF_MASK, 32'h1, 32'hFFFF_FFFF, "reset mask");
        rdchk(`CBS_OFF_CAP, 32'd100000, 32'hFFFF_FFFF, "reset cap");
        apb(1'b1, `CBS_OFF_MASK, 32'h0000_8000);
        rdchk(`CBS_OFF_MASK, 32'h0001_8000, 32'hFFFF_FFFF, "paired mask");
        rdchk(`CBS_OFF_CAP, 32'd50000, 32'hFFFF_FFFF, "freq cap");
        chk("cut len", 32'd50000, {15'h0, curve_len});
        $display("test pair done");
    endtask : t_pair
    task automatic t_len();
        apb(1'b1, `CBS_OFF_LEN, 32'd50001);
        rdchk(`CBS_OFF_STAT, 32'h1, 32'h1, "len perr");
        chk("len kept", 32'd50000, {15'h0, curve_len});
        apb(1'b1, `CBS_OFF_CTRL, 32'h1);
        apb(1'b1, `CBS_OFF_LEN, 32'd100000);
        chk("fast", 1, fast_mode);
        chk("fast len", 32'd100000, {15'h0, curve_len});
        apb(1'b1, `CBS_OFF_CTRL, 32'h0);
        @(posedge pclk);
        #1;
        chk("std", 0, fast_mode);
        chk("mode cut", 32'd50000, {15'h0, curve_len});
        $display("test len done");
    endtask : t_len
    task automatic t_rej();
        apb(1'b1, `CBS_OFF_STAT, 32'h3);
        apb(1'b1, `CBS_OFF_MASK, 32'h0002_0001);
        rdchk(`CBS_OFF_STAT, 32'h2, 32'h2, "mask rej");
        apb(1'b1, `CBS_OFF_MASK, 32'h0);
        chk("mask kept", 32'h0001_8000, {10'h0, sel_mask});
        apb(1'b1, `CBS_OFF_CTRL, 32'h2);
        // host keeps a second-demodulator and sensitivity channel in the mask
        apb(1'b1, `CBS_OFF_MASK, 32'h003F_FFFF);
        chk("dual max", 32'h003F_FFFF, {10'h0, sel_mask});
        // length is cut on the edge after the mask lands
        @(posedge pclk);
        #1;
        chk("len 22", 32'd4545, {15'h0, curve_len});
        $display("test reject done");
    endtask : t_rej
    task automatic t_enc();
        logic [4:0] ch[9] = '{0, 2, 3, 4, 7, 14, 15, 16, 1};
        int rw[9] = '{-20000, -5, 20000, 0, -4000, 0, 0, 0, 5};
        logic [15:0] ex[9] = '{16'hD8F0, 16'h0000, 16'h4650, 16'h009B, 16'hF448,
                               16'h7FFF, 16'h5678, 16'h1234, 16'h0000};
        apb(1'b1, `CBS_OFF_CTRL, 32'hE);
        apb(1'b1, `CBS_OFF_MASK, 32'h0003_C09D);
        for (int i = 0; i < 9; i++) begin
            send(ch[i], rw[i]);
            chk("store en", i < 8, store_en);
            chk("store chan", {27'h0, ch[i]}, {27'h0, store_chan});
            if (i < 8) chk("word", ex[i], store_word);
        end
        apb(1'b1, `CBS_OFF_RDSEL, 32'h1);
        rdchk(`CBS_OFF_STAT, 32'h0, 32'h4, "rd bad");
        apb(1'b1, `CBS_OFF_RDSEL, 32'h2);
        rdchk(`CBS_OFF_STAT, 32'h4, 32'h4, "rd ok");
        $display("test encode done");
    endtask : t_enc
    task automatic t_cnt();
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            point_done <= 1'b1;
            sweep_done <= (i < 2);
            @(posedge pclk);
            point_done <= 1'b0;
            sweep_done <= 1'b0;
        end
        rdchk(`CBS_OFF_POINTS, 32'd3, 32'hFFFF_FFFF, "points");
        rdchk(`CBS_OFF_SWEEPS, 32'd2, 32'hFFFF_FFFF, "sweeps");
        apb(1'b0, `CBS_OFF_LEN, 32'h0);
        rdchk(`CBS_OFF_POINTS, 32'd0, 32'hFFFF_FFFF, "len clr");
        @(posedge pclk);
        point_done <= 1'b1;
        @(posedge pclk);
        point_done <= 1'b0;
        apb(1'b1, `CBS_OFF_CMD, 32'h1);
        rdchk(`CBS_OFF_POINTS, 32'd0, 32'hFFFF_FFFF, "reinit");
        apb(1'b1, 8'h40, 32'h5);
        chk("unmapped err", 1, err);
        rdchk(8'h40, 32'h0, 32'hFFFF_FFFF, "unmapped rd");
        $display("test counters done");
    endtask : t_cnt
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_pair();
        t_len();
        t_rej();
        t_enc();
        t_cnt();
        final_report();
    end
endmodule : curve_buffer_channel_select_bench
